// >>> sd_enc_device.sv
// SD encoder control end: subcarrier word, mode bits, filter selection and SD timing counters
`timescale 1ns/1ps
`include "sd_enc_consts.svh"

// Behaviour
// - Subcarrier word is 32 bits in four bytes
// - Lowest subaddress holds least significant byte
// - Host writes bytes zero to three ascending
// - New word applies only after byte three
// - Host loads recommended NTSC or PAL bytes
// - Mode8 bit1 selects noninterlaced SD operation
// - Noninterlaced accepts 240 or 288 line frames
// - Source supplies 27 MHz clock when progressive
// - Sync from embedded codes or sync pins
// - All features stay available when progressive
// - Host picks standard and sets progressive bit
// - Mode2 bit4 selects square pixel timing
// - Source supplies square pixel clock rate
// - Square pixel changes line length counters
// - Filter register bits 4:2 pick luma response
// - Chroma select offers low-pass, CIF, QCIF
// - Gain enable picks one of 13 steps
// - Mode2 bit0 switches PrPb extended filter
// - PrPb filter off routes selected chroma filter
// - Timing reset holds counters, restarts field one
module sd_enc_device (
   input wire logic sys_clk,
   input wire logic reset,
   sd_enc_link.dev link,
   output sd_enc_pkg::luma_filter_e lumaFilter,
   output logic [3:0] gainStep,
   output logic [2:0] chromaFilter,
   output logic prpbSsafOn,
   output logic [2:0] prpbFilter,
   output logic squarePixel,
   output logic nonInterlaced,
   output sd_enc_pkg::video_std_e videoStd,
   output logic [10:0] pixelCount,
   output logic [9:0] lineCount,
   output logic [2:0] fieldNum,
   output logic [7:0] subcarrierPhase,
   output logic outValid,
   input wire logic outReady,
   output logic [15:0] outData
);
   import sd_enc_pkg::*;

   typedef struct packed {
      logic [7:0] filterReg;
      logic [7:0] mode2Reg;
      logic [7:0] mode4Reg;
      logic [7:0] mode7Reg;
      logic [7:0] mode8Reg;
      logic [3:0] gainReg;
      logic [31:0] fscShadow;
      logic [31:0] fscActive;
      logic [31:0] phaseAcc;
      logic [7:0] actFilter;
      logic [7:0] actMode2;
      logic [7:0] actMode7;
      logic [7:0] actMode8;
      logic [3:0] actGain;
      logic [10:0] hCount;
      logic [9:0] lCount;
      logic [2:0] field;
      logic rstSync1;
      logic rstSync2;
      logic rstPrev;
      logic holdTiming;
      logic phaseArmed;
      logic [23:0] byteHist;
      logic fPrev;
      logic hsPrev;
      logic vsPrev;
      logic [1:0][15:0] bufData;
      logic [1:0] bufCount;
      logic rdPtr;
      logic wrPtr;
      logic inReady;
      logic bufValid;
      logic [15:0] bufHead;
      logic [7:0] rdData;
      logic rdValid;
      logic [7:0] scPhase;
   } dev_state_s;

   dev_state_s st_reg;
   dev_state_s st_next;

   // Line length in clocks for the standard and pixel aspect
   function automatic logic [10:0] lineLen(input logic [1:0] std, input logic square);
      if (std[0])
         lineLen = square ? `SD_LINE_SQ_PAL : `SD_LINE_PAL;
      else
         lineLen = square ? `SD_LINE_SQ_NTSC : `SD_LINE_NTSC;
   endfunction

   // Lines per frame; progressive frames take half the lines, rounded down
   function automatic logic [9:0] frameLines(input logic [1:0] std, input logic nonInt);
      if (std[0])
         frameLines = nonInt ? `SD_LINES_PAL_P : `SD_LINES_PAL_I;
      else
         frameLines = nonInt ? `SD_LINES_NTSC_P : `SD_LINES_NTSC_I;
   endfunction

   // Register readback, unmapped offsets read as zero
   function automatic logic [7:0] readReg(input logic [7:0] addr, input dev_state_s s);
      unique case (addr)
         `SD_ADDR_FILTER: readReg = s.filterReg;
         `SD_ADDR_MODE2: readReg = s.mode2Reg;
         `SD_ADDR_MODE4: readReg = s.mode4Reg;
         `SD_ADDR_MODE7: readReg = s.mode7Reg;
         `SD_ADDR_MODE8: readReg = s.mode8Reg;
         `SD_ADDR_SUBCARRIER_FREQ_BYTE0: readReg = s.fscShadow[7:0];
         `SD_ADDR_SUBCARRIER_FREQ_BYTE1: readReg = s.fscShadow[15:8];
         `SD_ADDR_SUBCARRIER_FREQ_BYTE2: readReg = s.fscShadow[23:16];
         `SD_ADDR_SUBCARRIER_FREQ_BYTE3: readReg = s.fscShadow[31:24];
         `SD_ADDR_GAIN: readReg = {4'h0, s.gainReg};
         `SD_ADDR_FIELD: readReg = {5'h00, s.field};
         default: readReg = 8'h00;
      endcase
   endfunction

   always_comb begin
      logic push;
      logic pop;
      logic lineStart;
      logic fieldStart;
      logic rstRise;
      logic rstFall;
      logic syncH;
      logic syncV;
      logic [10:0] lenNow;
      logic [9:0] linesNow;
      logic [2:0] fieldsMax;
      sd_counter_reset_mode_e rstMode;
      push = 1'b0;
      pop = 1'b0;
      lineStart = 1'b0;
      fieldStart = 1'b0;
      syncH = 1'b0;
      syncV = 1'b0;
      rstRise = st_reg.rstSync2 && !st_reg.rstPrev;
      rstFall = !st_reg.rstSync2 && st_reg.rstPrev;
      rstMode = sd_counter_reset_mode_e'(st_reg.mode4Reg[`SD_MODE4_RST_LSB +: 2]);
      lenNow = lineLen(st_reg.actFilter[`SD_FLT_STD_LSB +: 2], st_reg.actMode2[`SD_MODE2_SQUARE]);
      linesNow = frameLines(st_reg.actFilter[`SD_FLT_STD_LSB +: 2], st_reg.actMode8[`SD_MODE8_NONINT]);
      fieldsMax = st_reg.actFilter[`SD_FLT_STD_LSB] ? `SD_FIELDS_PAL : `SD_FIELDS_NTSC;
      st_next = st_reg;

      // Register writes; the word goes live only with the top byte
      st_next.rdValid = 1'b0;
      if (link.regWrite) begin
         unique case (link.regAddr)
            `SD_ADDR_FILTER: st_next.filterReg = link.regWdata;
            `SD_ADDR_MODE2: st_next.mode2Reg = link.regWdata;
            `SD_ADDR_MODE4: st_next.mode4Reg = link.regWdata;
            `SD_ADDR_MODE7: st_next.mode7Reg = link.regWdata;
            `SD_ADDR_MODE8: st_next.mode8Reg = link.regWdata;
            `SD_ADDR_SUBCARRIER_FREQ_BYTE0: st_next.fscShadow[7:0] = link.regWdata;
            `SD_ADDR_SUBCARRIER_FREQ_BYTE1: st_next.fscShadow[15:8] = link.regWdata;
            `SD_ADDR_SUBCARRIER_FREQ_BYTE2: st_next.fscShadow[23:16] = link.regWdata;
            `SD_ADDR_SUBCARRIER_FREQ_BYTE3: begin
               st_next.fscShadow[31:24] = link.regWdata;
               st_next.fscActive = {link.regWdata, st_reg.fscShadow[23:0]};
            end
            // Steps beyond the last one are clamped, not wrapped
            `SD_ADDR_GAIN: st_next.gainReg = (link.regWdata[3:0] > `SD_GAIN_MAX) ? `SD_GAIN_MAX
                                           : link.regWdata[3:0];
            default: ;
         endcase
      end
      if (link.regRead) begin
         st_next.rdData = readReg(link.regAddr, st_reg);
         st_next.rdValid = 1'b1;
      end

      // Two-entry pixel buffer; the receiver may stall freely
      push = link.pixValid && st_reg.inReady;
      pop = st_reg.bufValid && outReady;
      if (push) begin
         st_next.bufData[st_reg.wrPtr] = link.pixData;
         st_next.wrPtr = ~st_reg.wrPtr;
      end
      if (pop)
         st_next.rdPtr = ~st_reg.rdPtr;
      st_next.bufCount = st_reg.bufCount + {1'b0, push} - {1'b0, pop};
      st_next.inReady = (st_next.bufCount != 2'd2);
      st_next.bufValid = (st_next.bufCount != 2'd0);
      st_next.bufHead = st_next.bufData[st_next.rdPtr];

      // Sync detection from pins or embedded codes
      st_next.hsPrev = link.hsyncN;
      st_next.vsPrev = link.vsyncN;
      if (push)
         st_next.byteHist = {st_reg.byteHist[15:0], link.pixData[7:0]};
      if (st_reg.actMode8[`SD_MODE8_EMBEDDED]) begin
         if (push && st_reg.byteHist == `SD_EAV_PREAMBLE && link.pixData[`SD_SYNC_BYTE_H]) begin
            syncH = 1'b1;
            st_next.fPrev = link.pixData[`SD_SYNC_BYTE_F];
            syncV = st_reg.fPrev && !link.pixData[`SD_SYNC_BYTE_F];
         end
      end else begin
         syncH = st_reg.hsPrev && !link.hsyncN;
         syncV = st_reg.vsPrev && !link.vsyncN;
      end

      // Reset pin passes two flip-flops before use
      st_next.rstSync1 = link.timingResetPin;
      st_next.rstSync2 = st_reg.rstSync1;
      st_next.rstPrev = st_reg.rstSync2;

      // Timing counters; lengths follow the latched mode bits
      if (syncH || st_reg.hCount == lenNow - 11'd1) begin
         st_next.hCount = 11'd0;
         lineStart = 1'b1;
         if (syncV || st_reg.lCount == linesNow - 10'd1) begin
            st_next.lCount = 10'd0;
            fieldStart = 1'b1;
         end else begin
            st_next.lCount = st_reg.lCount + 10'd1;
            // Interlaced frames hold two fields
            fieldStart = !st_reg.actMode8[`SD_MODE8_NONINT] && st_next.lCount == {1'b0, linesNow[9:1]};
         end
      end else begin
         st_next.hCount = st_reg.hCount + 11'd1;
      end
      if (fieldStart)
         st_next.field = (st_reg.field == fieldsMax) ? 3'd0 : st_reg.field + 3'd1;

      // New selections only at a line start, so no line is split
      if (lineStart) begin
         st_next.actFilter = st_reg.filterReg;
         st_next.actMode2 = st_reg.mode2Reg;
         st_next.actMode7 = st_reg.mode7Reg;
         st_next.actMode8 = st_reg.mode8Reg;
         st_next.actGain = st_reg.gainReg;
      end

      // Phase accumulator steps by the programmed word; phase reset zeroes it at the next field start
      st_next.phaseAcc = st_reg.phaseAcc + st_reg.fscActive;
      if (rstMode == RST_PHASE && rstRise)
         st_next.phaseArmed = 1'b1;
      if (st_reg.phaseArmed && fieldStart) begin
         st_next.phaseAcc = 32'h0000_0000;
         st_next.phaseArmed = 1'b0;
      end

      // Timing reset holds counters while the pin is high
      if (rstMode == RST_TIMING && rstRise)
         st_next.holdTiming = 1'b1;
      if (st_reg.holdTiming) begin
         st_next.hCount = 11'd0;
         st_next.lCount = 10'd0;
         st_next.field = 3'd0;
         if (rstFall) begin
            st_next.holdTiming = 1'b0;
            st_next.phaseAcc = 32'h0000_0000;
         end
      end
      st_next.scPhase = st_reg.phaseAcc[31:24];

      if (reset) begin
         st_next = '0;
         st_next.filterReg = `SD_FILTER_RESET;
         st_next.mode2Reg = `SD_MODE_RESET;
         st_next.mode4Reg = `SD_MODE_RESET;
         st_next.mode7Reg = `SD_MODE_RESET;
         st_next.mode8Reg = `SD_MODE_RESET;
         st_next.gainReg = `SD_GAIN_RESET;
         st_next.fscShadow = `SD_FSC_RESET;
         st_next.fscActive = `SD_FSC_RESET;
         st_next.actFilter = `SD_FILTER_RESET;
         st_next.actMode2 = `SD_MODE_RESET;
         st_next.actMode7 = `SD_MODE_RESET;
         st_next.actMode8 = `SD_MODE_RESET;
         st_next.actGain = `SD_GAIN_RESET;
         st_next.hsPrev = 1'b1;
         st_next.vsPrev = 1'b1;
         st_next.inReady = 1'b1;
      end
   end

   // Single state register
   always_ff @(posedge sys_clk) begin
      st_reg <= st_next;
   end

   // Outputs straight from state; gain shaping needs the extended response
   assign lumaFilter = (luma_filter_e'(st_reg.actFilter[`SD_FLT_LUMA_LSB +: 3]) == LUMA_EXT
                        && st_reg.actMode7[`SD_MODE7_GAIN_EN]) ? LUMA_EXT_GAIN
                       : luma_filter_e'(st_reg.actFilter[`SD_FLT_LUMA_LSB +: 3]);
   assign gainStep = st_reg.actGain;
   assign chromaFilter = st_reg.actFilter[`SD_FLT_CHROMA_LSB +: 3];
   assign prpbSsafOn = st_reg.actMode2[`SD_MODE2_PRPB_EXTENDED_RESPONSE_FILTER];
   assign prpbFilter = st_reg.actMode2[`SD_MODE2_PRPB_EXTENDED_RESPONSE_FILTER] ? 3'd0
                       : st_reg.actFilter[`SD_FLT_CHROMA_LSB +: 3];
   assign squarePixel = st_reg.actMode2[`SD_MODE2_SQUARE];
   assign nonInterlaced = st_reg.actMode8[`SD_MODE8_NONINT];
   assign videoStd = video_std_e'(st_reg.actFilter[`SD_FLT_STD_LSB +: 2]);
   assign pixelCount = st_reg.hCount;
   assign lineCount = st_reg.lCount;
   assign fieldNum = st_reg.field;
   assign subcarrierPhase = st_reg.scPhase;
   assign outValid = st_reg.bufValid;
   assign outData = st_reg.bufHead;
   assign link.pixReady = st_reg.inReady;
   assign link.regRdata = st_reg.rdData;
   assign link.regRdValid = st_reg.rdValid;
endmodule // sd_enc_device

// >>> sd_enc_consts.svh
// Register offsets, field positions, reset values and timing counts for the SD encoder control
`ifndef SD_ENC_CONSTS_SVH
`define SD_ENC_CONSTS_SVH

`define SD_ADDR_FILTER 8'h80
`define SD_ADDR_MODE2 8'h82
`define SD_ADDR_MODE4 8'h84
`define SD_ADDR_MODE7 8'h87
`define SD_ADDR_MODE8 8'h88
`define SD_ADDR_SUBCARRIER_FREQ_BYTE0 8'h8C
`define SD_ADDR_SUBCARRIER_FREQ_BYTE1 8'h8D
`define SD_ADDR_SUBCARRIER_FREQ_BYTE2 8'h8E
`define SD_ADDR_SUBCARRIER_FREQ_BYTE3 8'h8F
`define SD_ADDR_GAIN 8'hA2
`define SD_ADDR_FIELD 8'hBB

`define SD_FLT_STD_LSB 0
`define SD_FLT_LUMA_LSB 2
`define SD_FLT_CHROMA_LSB 5
`define SD_MODE2_PRPB_EXTENDED_RESPONSE_FILTER 0
`define SD_MODE2_SQUARE 4
`define SD_MODE4_RST_LSB 1
`define SD_MODE7_GAIN_EN 4
`define SD_MODE8_EMBEDDED 0
`define SD_MODE8_NONINT 1

`define SD_FILTER_RESET 8'h00
`define SD_MODE_RESET 8'h00
`define SD_GAIN_RESET 4'h0
`define SD_GAIN_MAX 4'hC
`define SD_FSC_RESET 32'h21F0_7C1F
`define SD_FSC_NTSC 32'h21F0_7C1F
`define SD_FSC_PAL 32'h2A09_8ACB
`define SD_MODE8_PROGRESSIVE 8'h02

`define SD_LINE_NTSC 11'h6B4
`define SD_LINE_PAL 11'h6C0
`define SD_LINE_SQ_NTSC 11'h618
`define SD_LINE_SQ_PAL 11'h760
`define SD_LINES_NTSC_I 10'h20D
`define SD_LINES_PAL_I 10'h271
`define SD_LINES_NTSC_P 10'h106
`define SD_LINES_PAL_P 10'h138
`define SD_FIELDS_NTSC 3'h3
`define SD_FIELDS_PAL 3'h7

`define SD_EAV_PREAMBLE 24'hFF_0000
`define SD_SYNC_BYTE_H 4
`define SD_SYNC_BYTE_F 6

`endif

// >>> sd_enc_pkg.sv
// Types shared by the SD encoder control and its pixel source
package sd_enc_pkg;
   typedef enum logic [1:0] {STD_NTSC, STD_PAL, STD_PAL_M, STD_PAL_N} video_std_e;
   typedef enum logic [1:0] {RST_OFF, RST_PHASE, RST_TIMING, RST_FREQ_LOCK} sd_counter_reset_mode_e;
   typedef enum logic [2:0] {LUMA_LPF_NTSC, LUMA_LPF_PAL, LUMA_NOTCH_NTSC, LUMA_NOTCH_PAL,
                             LUMA_EXT, LUMA_EXT_GAIN, LUMA_CIF, LUMA_QCIF} luma_filter_e;
   typedef enum logic [2:0] {CMD_WRITE, CMD_READ, CMD_FSC_NTSC, CMD_FSC_PAL,
                             CMD_PROG_NTSC, CMD_PROG_PAL} host_cmd_e;
   typedef enum logic [1:0] {H_IDLE, H_SEQ, H_READ_WAIT} host_state_e;
   typedef struct packed {
      logic last;
      logic [7:0] addr;
      logic [7:0] data;
   } seq_entry_s;
endpackage

// >>> sd_enc_link.sv
// Link between the pixel source and the SD encoder control
`timescale 1ns/1ps
interface sd_enc_link;
   logic regWrite;
   logic regRead;
   logic [7:0] regAddr;
   logic [7:0] regWdata;
   logic [7:0] regRdata;
   logic regRdValid;
   logic pixValid;
   logic pixReady;
   logic [15:0] pixData;
   logic hsyncN;
   logic vsyncN;
   logic timingResetPin;

   modport dev(input regWrite, regRead, regAddr, regWdata, pixValid, pixData, hsyncN, vsyncN,
               timingResetPin, output regRdata, regRdValid, pixReady);
   modport src(output regWrite, regRead, regAddr, regWdata, pixValid, pixData, hsyncN, vsyncN,
               timingResetPin, input regRdata, regRdValid, pixReady);
endinterface // sd_enc_link

// >>> sd_pixel_source.sv
// Pixel source end: register programming sequences and pixel stream toward the encoder
`timescale 1ns/1ps
`include "sd_enc_consts.svh"

module sd_pixel_source (
   input wire logic sys_clk,
   input wire logic reset,
   sd_enc_link.src link,
   input wire logic cmdValid,
   output logic cmdReady,
   input sd_enc_pkg::host_cmd_e cmdKind,
   input wire logic [7:0] cmdAddr,
   input wire logic [7:0] cmdData,
   output logic rspValid,
   output logic [7:0] rspData,
   input wire logic srcValid,
   output logic srcReady,
   input wire logic [15:0] srcData,
   input wire logic srcHsyncN,
   input wire logic srcVsyncN,
   input wire logic srcTimingReset
);
   import sd_enc_pkg::*;

   typedef struct packed {
      host_state_e state;
      host_cmd_e kind;
      logic [2:0] step;
      logic [7:0] addr;
      logic [7:0] data;
      logic regWrite;
      logic regRead;
      logic [7:0] regAddr;
      logic [7:0] regWdata;
      logic cmdReady;
      logic rspValid;
      logic [7:0] rspData;
      logic pixValid;
      logic [15:0] pixData;
      logic srcReady;
      logic hsN;
      logic vsN;
      logic rstPin;
   } src_state_s;

   src_state_s st_reg;
   src_state_s st_next;

   // Byte i of a subcarrier word, lowest subaddress first
   function automatic logic [7:0] fscByte(input logic [31:0] word, input logic [1:0] idx);
      fscByte = word[{idx, 3'b000} +: 8];
   endfunction

   // One step of each programming sequence
   function automatic seq_entry_s seqStep(input host_cmd_e kind, input logic [2:0] step,
                                          input logic [7:0] addr, input logic [7:0] data);
      logic [31:0] word;
      logic [2:0] fscIdx;
      word = (kind == CMD_FSC_PAL || kind == CMD_PROG_PAL) ? `SD_FSC_PAL : `SD_FSC_NTSC;
      fscIdx = (kind == CMD_PROG_NTSC || kind == CMD_PROG_PAL) ? step - 3'd2 : step;
      seqStep.last = 1'b0;
      seqStep.addr = `SD_ADDR_SUBCARRIER_FREQ_BYTE0 + {6'h00, fscIdx[1:0]};
      seqStep.data = fscByte(word, fscIdx[1:0]);
      unique case (kind)
         CMD_WRITE: begin
            seqStep.last = 1'b1;
            seqStep.addr = addr;
            seqStep.data = data;
         end
         CMD_PROG_NTSC, CMD_PROG_PAL: begin
            // Standard first, then progressive bit, then the word
            if (step == 3'd0) begin
               seqStep.addr = `SD_ADDR_FILTER;
               seqStep.data = {data[7:2], (kind == CMD_PROG_PAL) ? STD_PAL : STD_NTSC};
            end else if (step == 3'd1) begin
               seqStep.addr = `SD_ADDR_MODE8;
               seqStep.data = `SD_MODE8_PROGRESSIVE;
            end
            seqStep.last = (step == 3'd5);
         end
         default: seqStep.last = (step == 3'd3);
      endcase
   endfunction

   always_comb begin
      seq_entry_s ent;
      ent = seqStep(st_reg.kind, st_reg.step, st_reg.addr, st_reg.data);
      st_next = st_reg;
      st_next.regWrite = 1'b0;
      st_next.regRead = 1'b0;
      st_next.rspValid = 1'b0;

      // Command sequencer, one register access per cycle
      unique case (st_reg.state)
         H_IDLE: begin
            if (cmdValid && st_reg.cmdReady) begin
               st_next.kind = cmdKind;
               st_next.addr = cmdAddr;
               st_next.data = cmdData;
               st_next.step = 3'd0;
               st_next.cmdReady = 1'b0;
               if (cmdKind == CMD_READ) begin
                  st_next.regRead = 1'b1;
                  st_next.regAddr = cmdAddr;
                  st_next.state = H_READ_WAIT;
               end else begin
                  st_next.state = H_SEQ;
               end
            end
         end
         H_SEQ: begin
            st_next.regWrite = 1'b1;
            st_next.regAddr = ent.addr;
            st_next.regWdata = ent.data;
            st_next.step = st_reg.step + 3'd1;
            if (ent.last) begin
               st_next.state = H_IDLE;
               st_next.cmdReady = 1'b1;
               st_next.rspValid = 1'b1;
               st_next.rspData = 8'h00;
            end
         end
         H_READ_WAIT: begin
            if (link.regRdValid) begin
               st_next.rspValid = 1'b1;
               st_next.rspData = link.regRdata;
               st_next.state = H_IDLE;
               st_next.cmdReady = 1'b1;
            end
         end
      endcase

      // One-word stage; holds until the encoder takes it
      if (st_reg.pixValid && link.pixReady)
         st_next.pixValid = 1'b0;
      if (srcValid && st_reg.srcReady) begin
         st_next.pixValid = 1'b1;
         st_next.pixData = srcData;
      end
      st_next.srcReady = !st_next.pixValid;

      // Sync and reset levels registered on sys_clk, one cycle behind the inputs
      st_next.hsN = srcHsyncN;
      st_next.vsN = srcVsyncN;
      st_next.rstPin = srcTimingReset;

      if (reset) begin
         st_next = '0;
         st_next.state = H_IDLE;
         st_next.kind = CMD_WRITE;
         st_next.cmdReady = 1'b1;
         st_next.srcReady = 1'b1;
         st_next.hsN = 1'b1;
         st_next.vsN = 1'b1;
      end
   end

   // Single state register
   always_ff @(posedge sys_clk) begin
      st_reg <= st_next;
   end

   // Outputs straight from state
   assign cmdReady = st_reg.cmdReady;
   assign rspValid = st_reg.rspValid;
   assign rspData = st_reg.rspData;
   assign srcReady = st_reg.srcReady;
   assign link.regWrite = st_reg.regWrite;
   assign link.regRead = st_reg.regRead;
   assign link.regAddr = st_reg.regAddr;
   assign link.regWdata = st_reg.regWdata;
   assign link.pixValid = st_reg.pixValid;
   assign link.pixData = st_reg.pixData;
   assign link.hsyncN = st_reg.hsN;
   assign link.vsyncN = st_reg.vsN;
   assign link.timingResetPin = st_reg.rstPin;
endmodule // sd_pixel_source

// >>> sd_enc_assertions.sv
// Link checks between the pixel source and the SD encoder control
`timescale 1ns/1ps
module sd_enc_assertions (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic regRdValid,
   input wire logic pixValid,
   input wire logic pixReady,
   input wire logic [15:0] pixData,
   input wire logic vsyncN
);
   // One clock domain, so defaults cover every check
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_read_answer_next: assert property (regRead |=> regRdValid)
      else $error("read not answered");
   a_rdvalid_has_cause: assert property (regRdValid |-> $past(regRead))
      else $error("stray read valid");
   a_one_access_kind: assert property (!(regWrite && regRead))
      else $error("write and read together");
   a_fsc_byte_order: assert property (regWrite && regAddr == 8'h8D |-> $past(regAddr) == 8'h8C)
      else $error("byte one out of order");
   a_fsc_last_byte: assert property (regWrite && regAddr == 8'h8F |-> $past(regWrite && regAddr == 8'h8E))
      else $error("byte three out of order");
   a_pix_held_stall: assert property (pixValid && !pixReady |=> pixValid && $stable(pixData))
      else $error("pixel dropped in stall");
   a_ready_after_reset: assert property ($fell(reset) |-> pixReady)
      else $error("buffer not ready");
   a_sync_idle_reset: assert property ($fell(reset) |-> vsyncN)
      else $error("sync not idle");
endmodule // sd_enc_assertions

// >>> sd_subcarrier_mode_filter_ctrl_bench.sv
// Bench joining the pixel source and the SD encoder control
`timescale 1ns/1ps
`include "sd_enc_consts.svh"
module sd_subcarrier_mode_filter_ctrl_bench;
   import sd_enc_pkg::*;
   logic sys_clk = 0, reset = 1, cmdValid = 0, cmdReady, rspValid, srcValid = 0, srcReady, outValid, outReady = 0;
   logic prpbSsafOn, squarePixel, nonInterlaced, srcTimingReset = 0, srcHsyncN = 1, srcVsyncN = 1;
   host_cmd_e cmdKind = CMD_WRITE;
   logic [7:0] cmdAddr = 0, cmdData = 0, rspData, subcarrierPhase;
   logic [15:0] srcData = 0, outData;
   luma_filter_e lumaFilter;
   video_std_e videoStd;
   logic [3:0] gainStep;
   logic [2:0] chromaFilter, prpbFilter, fieldNum;
   logic [10:0] pixelCount;
   logic [9:0] lineCount;
   int errors = 0, num_checks = 0, cycles = 0;
   sd_enc_link link();
   sd_enc_device sd_enc_device_i (.sys_clk, .reset, .link(link.dev), .lumaFilter, .gainStep, .chromaFilter,
      .prpbSsafOn, .prpbFilter, .squarePixel, .nonInterlaced, .videoStd, .pixelCount, .lineCount, .fieldNum,
      .subcarrierPhase, .outValid, .outReady, .outData);
   sd_pixel_source sd_pixel_source_i (.sys_clk, .reset, .link(link.src), .cmdValid, .cmdReady, .cmdKind, .cmdAddr,
      .cmdData, .rspValid, .rspData, .srcValid, .srcReady, .srcData, .srcHsyncN, .srcVsyncN, .srcTimingReset);
   sd_enc_assertions sd_enc_assertions_i (.sys_clk, .reset, .regWrite(link.regWrite), .regRead(link.regRead),
      .regAddr(link.regAddr), .regRdValid(link.regRdValid), .pixValid(link.pixValid), .pixReady(link.pixReady),
      .pixData(link.pixData), .vsyncN(link.vsyncN));
   // 200 MHz clock
   always #2.5 sys_clk = ~sys_clk;
   // Hang guard, far above the run's length
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 32'h0001_3880) begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Request held until ready seen at a sampled edge
   task automatic cmd(host_cmd_e k, logic [7:0] a, logic [7:0] d);
      logic r;
      @(posedge sys_clk);
      cmdKind <= k;
      cmdAddr <= a;
      cmdData <= d;
      cmdValid <= 1'b1;
      do begin
         @(negedge sys_clk);
         r = cmdReady;
         @(posedge sys_clk);
      end while (r !== 1'b1);
      cmdValid <= 1'b0;
      do @(negedge sys_clk); while (rspValid !== 1'b1);
   endtask
   task automatic push(logic [15:0] w);
      logic r;
      @(posedge sys_clk);
      srcData <= w;
      srcValid <= 1'b1;
      do begin
         @(negedge sys_clk);
         r = srcReady;
         @(posedge sys_clk);
      end while (r !== 1'b1);
      srcValid <= 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic next_line();
      repeat (2) @(negedge sys_clk);
      while (pixelCount !== 11'h000) @(negedge sys_clk);
   endtask
   // Over 256 clocks the top byte moves by the word's byte 2, or one more
   task automatic phase_chk(logic [7:0] lo);
      logic [7:0] p0;
      logic [7:0] d;
      repeat (4) @(negedge sys_clk);
      p0 = subcarrierPhase;
      repeat (256) @(negedge sys_clk);
      d = subcarrierPhase - p0;
      chk("phase step", lo, (d == lo + 8'h01) ? lo : d);
   endtask
   task automatic t_word(logic [31:0] w);
      for (int i = 0; i < 4; i++) begin
         cmd(CMD_READ, 8'h8C + 8'(i), 8'h00);
         chk("fsc byte", w[8*i+:8], rspData);
      end
   endtask
   task automatic t_fsc();
      t_word(`SD_FSC_RESET);
      phase_chk(8'hF0);
      cmd(CMD_WRITE, 8'h8C, 8'hCB);
      phase_chk(8'hF0);
      cmd(CMD_PROG_PAL, 8'h00, 8'h00);
      t_word(32'h2A09_8ACB);
      phase_chk(8'h09);
      next_line();
      chk("nonint", 1, nonInterlaced);
      chk("std", STD_PAL, videoStd);
   endtask
   task automatic t_filters();
      for (int k = 0; k < 8; k++) begin
         cmd(CMD_WRITE, 8'h80, {3'(k), 3'(k), 2'b01});
         if (k > 0 && pixelCount > 11'h008) chk("luma held", k - 1, lumaFilter);
         next_line();
         chk("luma", k, lumaFilter);
         chk("chroma", k, chromaFilter);
         chk("prpb path", k, prpbFilter);
      end
      cmd(CMD_WRITE, 8'h87, 8'h10);
      cmd(CMD_WRITE, 8'hA2, 8'h0F);
      cmd(CMD_WRITE, 8'h80, 8'h11);
      next_line();
      chk("luma gain", LUMA_EXT_GAIN, lumaFilter);
      chk("gain clamp", 4'hC, gainStep);
   endtask
   task automatic t_square();
      int n = 0;
      cmd(CMD_WRITE, 8'h82, 8'h11);
      next_line();
      chk("square", 1, squarePixel);
      chk("prpb on", 1, prpbSsafOn);
      chk("prpb path", 0, prpbFilter);
      do begin
         @(negedge sys_clk);
         n++;
      end while (pixelCount !== 11'h000);
      chk("sq line", `SD_LINE_SQ_PAL, n);
   endtask
   // Receiver stalls while three words go in, then drains in order
   task automatic t_buffer();
      for (int i = 0; i < 3; i++) push(16'h1230 + 16'(i));
      repeat (4) @(negedge sys_clk);
      chk("full", 0, link.pixReady);
      @(posedge sys_clk);
      outReady <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         do @(negedge sys_clk); while (outValid !== 1'b1);
         chk("out word", 16'h1230 + 16'(i), outData);
         @(posedge sys_clk);
      end
      outReady <= 1'b0;
   endtask
   task automatic t_treset();
      cmd(CMD_WRITE, 8'h84, 8'h04);
      @(posedge sys_clk);
      srcTimingReset <= 1'b1;
      repeat (12) @(negedge sys_clk);
      chk("held pix", 0, pixelCount);
      chk("held line", 0, lineCount);
      @(posedge sys_clk);
      srcTimingReset <= 1'b0;
      repeat (8) @(negedge sys_clk);
      chk("field", 0, fieldNum);
      chk("resume pix", 3, pixelCount);
      chk("phase reset", 8'h54, subcarrierPhase);
      @(posedge sys_clk);
      srcHsyncN <= 1'b0;
      repeat (3) @(negedge sys_clk);
      chk("hsync wrap", 0, pixelCount);
      cmd(CMD_FSC_NTSC, 8'h00, 8'h00);
      t_word(`SD_FSC_NTSC);
   endtask
   task automatic tally_and_finish();
      $display("errors=%0d checks=%0d", errors, num_checks);
      if (errors == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Reset for 16 clocks, then each scenario in turn
   initial begin
      repeat (16) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      t_fsc();
      t_filters();
      t_square();
      t_buffer();
      t_treset();
      tally_and_finish();
   end
endmodule // sd_subcarrier_mode_filter_ctrl_bench
